// *** src/spc_pkg.sv ***
/*
 * shared constants and types of the standby pin state control block.
 * assumes one clock, pins sampled synchronously, and power mode decoded elsewhere.
 */
// Overview of operation
// - a relocatable peripheral signal drives only the pin its selection picks.
// - whole low period of the external reset pin counts as pin reset.
// - pin function settings cannot be applied while any reset is active.
// - a floating pin has its output drive turned off.
// - an unusable input reads as constant 0 inside the device.
// - run, sleep and standby with level select 0 keep the previous pin state.
// - a kept pin owned by a running peripheral follows that peripheral.
// - a kept port pin holds the last port output value.
// - the high-speed oscillator stops in the timer, RTC and STOP standby modes; the sub oscillator stops only in STOP.
package spc_pkg;

    localparam int SPC_NUM_SIG = 4;
    localparam int SPC_NUM_ALT = 2;
    localparam int SPC_NUM_PIN = SPC_NUM_SIG * SPC_NUM_ALT;

    localparam logic SPC_RST_LEVEL = 1'b0;

    typedef enum logic [5:0] {
        SPC_MODE_RUN       = 6'b00_0001,
        SPC_MODE_SLEEP     = 6'b00_0010,
        SPC_MODE_SUB_TIMER = 6'b00_0100,
        SPC_MODE_LCR_TIMER = 6'b00_1000,
        SPC_MODE_RTC       = 6'b01_0000,
        SPC_MODE_STOP      = 6'b10_0000
    } spc_mode_e;

    typedef struct packed {
        logic [SPC_NUM_PIN-1:0] gpioOut;
        logic [SPC_NUM_PIN-1:0] gpioOe;
        logic [SPC_NUM_SIG-1:0] periphEn;
        logic [SPC_NUM_SIG-1:0] relocSel;
    } spc_cfg_s;

    typedef struct packed {
        logic value;
        logic enable;
    } spc_drive_s;

    localparam spc_cfg_s SPC_CFG_RESET = '0;
    localparam spc_drive_s SPC_DRIVE_OFF = '0;

endpackage : spc_pkg

// *** src/spc_pin_hold.sv ***
/*
 * per-pin hold latch for the port output value and enable.
 * assumes the caller raises holdEn for the whole of a keep-state standby period.
 */
`timescale 1ns/1ps
module spc_pin_hold
    import spc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       holdEn,
    input  spc_drive_s      liveDrive,
    output spc_drive_s      heldDrive
);

    spc_drive_s driveQ_q;
    spc_drive_s driveQ_d;

    // tracks live value until hold, then freezes the value seen just before entry
    assign driveQ_d  = holdEn ? driveQ_q : liveDrive;
    assign heldDrive = driveQ_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            driveQ_q <= SPC_DRIVE_OFF;
        end else begin
            driveQ_q <= driveQ_d;
        end
    end

endmodule : spc_pin_hold

// *** src/spc_standby_pin_state_control.sv ***
/*
 * pin state control across reset, run, sleep and standby modes.
 * assumes pins and mode inputs synchronous to clk; the pad turns enable into drive.
 */
`timescale 1ns/1ps
module spc_standby_pin_state_control
    import spc_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   external_reset_n,
    input  wire logic                   porReset,
    input  wire logic                   lvdReset,
    input  wire logic                   internalReset,
    input  spc_mode_e                   powerMode,
    input  wire logic                   standby_pin_level_sel,
    input  wire logic                   cfgWrValid,
    output logic                        cfgWrReady,
    input  spc_cfg_s                    cfgWrData,
    input  wire logic [SPC_NUM_SIG-1:0] periphOut,
    input  wire logic [SPC_NUM_SIG-1:0] periphOe,
    output logic      [SPC_NUM_SIG-1:0] periphIn,
    input  wire logic [SPC_NUM_PIN-1:0] extIntEn,
    output logic      [SPC_NUM_PIN-1:0] gpioIn,
    input  wire logic [SPC_NUM_PIN-1:0] pinIn,
    output logic      [SPC_NUM_PIN-1:0] pinOut,
    output logic      [SPC_NUM_PIN-1:0] pinOe,
    output logic                        hsOscStop,
    output logic                        subOscStop
);

    function automatic logic isStandby(input spc_mode_e m);
        isStandby = !(m == SPC_MODE_RUN || m == SPC_MODE_SLEEP);
    endfunction : isStandby

    function automatic logic [1:0] oscStops(input spc_mode_e m);
        unique case (m)
            SPC_MODE_RUN, SPC_MODE_SLEEP:           oscStops = 2'b00;
            SPC_MODE_SUB_TIMER, SPC_MODE_LCR_TIMER,
            SPC_MODE_RTC:                           oscStops = 2'b10;
            SPC_MODE_STOP:                          oscStops = 2'b11;
            default:                                oscStops = 2'b11;
        endcase
    endfunction : oscStops

    spc_cfg_s               cfgQ_q;
    spc_cfg_s               cfgQ_d;
    logic [SPC_NUM_PIN-1:0] pinOut_q;
    logic [SPC_NUM_PIN-1:0] pinOut_d;
    logic [SPC_NUM_PIN-1:0] pinOe_q;
    logic [SPC_NUM_PIN-1:0] pinOe_d;
    logic [SPC_NUM_PIN-1:0] pinInt_q;
    logic [SPC_NUM_PIN-1:0] pinInt_d;
    logic [1:0]             osc_q;
    logic [1:0]             osc_d;
    wire                    pinReset;
    wire                    inStandby;
    wire                    floatMode;
    logic [SPC_NUM_PIN-1:0] routed;
    logic [SPC_NUM_PIN-1:0] floatPin;
    logic [SPC_NUM_PIN-1:0] selOut;
    logic [SPC_NUM_PIN-1:0] selOe;

    // any reset source, the external pin low for its whole low period
    assign pinReset   = (external_reset_n == SPC_RST_LEVEL) || porReset || lvdReset
                        || internalReset;
    assign inStandby  = isStandby(powerMode);
    assign floatMode  = inStandby && standby_pin_level_sel;
    // settings are refused, not queued, while reset holds
    assign cfgWrReady = !pinReset;
    assign cfgQ_d     = (cfgWrValid && cfgWrReady) ? cfgWrData : cfgQ_q;

    genvar p;
    generate
        for (p = 0; p < SPC_NUM_PIN; p++) begin : g_pin
            localparam int SIG = p / SPC_NUM_ALT;
            localparam logic ALT = 1'(p % SPC_NUM_ALT);
            spc_drive_s liveDrive;
            spc_drive_s heldDrive;
            wire        holdEn;

            assign routed[p]   = cfgQ_q.periphEn[SIG] && (cfgQ_q.relocSel[SIG] == ALT);
            assign liveDrive   = '{value: cfgQ_q.gpioOut[p], enable: cfgQ_q.gpioOe[p]};
            // outside reset, extint pins keep function; others float only in standby with level select set
            assign floatPin[p] = pinReset || (floatMode && !extIntEn[p]);
            assign holdEn      = inStandby;
            // a running peripheral keeps driving; a port pin shows its hold stage value, frozen in standby
            assign selOut[p]   = routed[p] ? periphOut[SIG] : heldDrive.value;
            assign selOe[p]    = routed[p] ? periphOe[SIG] : heldDrive.enable;
            assign pinOe_d[p]  = !floatPin[p] && selOe[p];
            assign pinOut_d[p] = !floatPin[p] && selOut[p];
            assign pinInt_d[p] = !floatPin[p] && pinIn[p];

            spc_pin_hold u_hold (
                .clk       (clk),
                .rst_n     (rst_n),
                .holdEn    (holdEn),
                .liveDrive (liveDrive),
                .heldDrive (heldDrive)
            );
        end
        for (p = 0; p < SPC_NUM_SIG; p++) begin : g_sig
            // input taken only from the selected pin
            assign periphIn[p] = pinInt_q[p * SPC_NUM_ALT + int'(cfgQ_q.relocSel[p])];
        end
    endgenerate

    assign osc_d      = oscStops(powerMode);
    assign pinOut     = pinOut_q;
    assign pinOe      = pinOe_q;
    assign gpioIn     = pinInt_q;
    assign hsOscStop  = osc_q[1];
    assign subOscStop = osc_q[0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgQ_q   <= SPC_CFG_RESET;
            pinOut_q <= '0;
            pinOe_q  <= '0;
            pinInt_q <= '0;
            osc_q    <= 2'b00;
        end else begin
            cfgQ_q   <= cfgQ_d;
            pinOut_q <= pinOut_d;
            pinOe_q  <= pinOe_d;
            pinInt_q <= pinInt_d;
            osc_q    <= osc_d;
        end
    end

    sequence keepPin0;
        inStandby && !standby_pin_level_sel && !pinReset && !routed[0];
    endsequence

    sequence keepPin0Twice;
        keepPin0 [*2];
    endsequence

    chk_reloc_route: assert property (@(posedge clk) disable iff (!rst_n)
        (cfgQ_q.periphEn[0] && cfgQ_q.relocSel[0] && !pinReset && !inStandby)
        |=> (pinOut_q[1] == $past(periphOut[0]))
            && (pinOe_q[1] == $past(periphOe[0])))
        else $error("peripheral signal not on its selected pin");

    chk_ext_reset_hiz: assert property (@(posedge clk) disable iff (!rst_n)
        !external_reset_n |=> (pinOe_q == '0) && (pinInt_q == '0))
        else $error("pins driven during external reset");

    chk_cfg_blocked: assert property (@(posedge clk) disable iff (!rst_n)
        (pinReset && cfgWrValid) |=> $stable(cfgQ_q))
        else $error("settings applied during reset");

    chk_spl_float: assert property (@(posedge clk) disable iff (!rst_n)
        (floatMode && !extIntEn[0]) |=> !pinOe_q[0] && !pinInt_q[0])
        else $error("pin not floated in standby with level select set");

    chk_hiz_nodrive: assert property (@(posedge clk) disable iff (!rst_n)
        floatPin[2] |=> !pinOe_q[2] && !pinOut_q[2])
        else $error("floating pin still driven");

    chk_input_fixed: assert property (@(posedge clk) disable iff (!rst_n)
        (floatPin[3] && pinIn[3]) |=> !gpioIn[3])
        else $error("unusable input not fixed at zero");

    chk_keep_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (($rose(inStandby) && !$past(routed[0]) && !$past(pinReset)) and keepPin0)
        |=> pinOe_q[0] == $past(cfgQ_q.gpioOe[0], 2))
        else $error("previous pin state not kept on standby entry");

    chk_periph_follow: assert property (@(posedge clk) disable iff (!rst_n)
        (inStandby && routed[1] && !floatPin[1]) |=> pinOe_q[1] == $past(periphOe[0]))
        else $error("kept pin not following peripheral");

    chk_port_hold: assert property (@(posedge clk) disable iff (!rst_n)
        keepPin0Twice |=> $stable(pinOut_q[0]) && $stable(pinOe_q[0]))
        else $error("port output not held in standby");

    chk_osc_stop: assert property (@(posedge clk) disable iff (!rst_n)
        (powerMode == SPC_MODE_STOP) |=> hsOscStop && subOscStop)
        else $error("oscillators running in stop mode");

    chk_osc_run: assert property (@(posedge clk) disable iff (!rst_n)
        (powerMode == SPC_MODE_RTC) ##1 (powerMode == SPC_MODE_RUN) |=> !hsOscStop && !subOscStop)
        else $error("oscillator stop wrong after wake");

    chk_extint_live: assert property (@(posedge clk) disable iff (!rst_n)
        (floatMode && extIntEn[1] && !pinReset)
        |=> (pinOe_q[1] == $past(selOe[1])) && (pinInt_q[1] == $past(pinIn[1])))
        else $error("interrupt pin floated in standby");

endmodule : spc_standby_pin_state_control

// *** tb/spc_board_model.sv ***
/*
 * board model: gives every undriven pin the level the board puts on it.
 * assumes pinOe high means the device drives the pin.
 */
`timescale 1ns/1ps
module spc_board_model
    import spc_pkg::*;
(
    input  wire logic [SPC_NUM_PIN-1:0] pinOut,
    input  wire logic [SPC_NUM_PIN-1:0] pinOe,
    input  wire logic [SPC_NUM_PIN-1:0] boardLvl,
    output logic      [SPC_NUM_PIN-1:0] pinIn
);
    // a floating pin reads the board level, never the last driven value
    assign pinIn = (pinOe & pinOut) | (~pinOe & boardLvl);
endmodule : spc_board_model

// *** tb/spc_standby_pin_state_control_tb_top.sv ***
/*
 * self-checking bench for the pin state control block.
 * assumes the board model on the pins and fixed cycle latencies.
 */
`timescale 1ns/1ps
module spc_standby_pin_state_control_tb_top
    import spc_pkg::*;
;
    logic                   clk, rst_n, external_reset_n, porReset, lvdReset, internalReset;
    logic                   standby_pin_level_sel, cfgWrValid, cfgWrReady, hsOscStop, subOscStop;
    spc_mode_e              powerMode;
    spc_cfg_s               cfgWrData;
    logic [SPC_NUM_SIG-1:0] periphOut, periphOe, periphIn;
    logic [SPC_NUM_PIN-1:0] extIntEn, gpioIn, pinIn, pinOut, pinOe, boardLvl;
    int                     mismatches, checks_done;

    spc_standby_pin_state_control DUT (.clk(clk), .rst_n(rst_n),
        .external_reset_n(external_reset_n), .porReset(porReset), .lvdReset(lvdReset),
        .internalReset(internalReset), .powerMode(powerMode),
        .standby_pin_level_sel(standby_pin_level_sel), .cfgWrValid(cfgWrValid),
        .cfgWrReady(cfgWrReady), .cfgWrData(cfgWrData), .periphOut(periphOut),
        .periphOe(periphOe), .periphIn(periphIn), .extIntEn(extIntEn), .gpioIn(gpioIn),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .hsOscStop(hsOscStop),
        .subOscStop(subOscStop));
    spc_board_model board (.pinOut(pinOut), .pinOe(pinOe), .boardLvl(boardLvl), .pinIn(pinIn));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task wr(input spc_cfg_s c);
        @(posedge clk);
        cfgWrValid <= 1'b1;
        cfgWrData  <= c;
        @(posedge clk);
        cfgWrValid <= 1'b0;
        // port pins lag the taken write by two edges through the hold stage
        settle(2);
    endtask : wr

    task mode(input spc_mode_e m, input logic s);
        @(posedge clk);
        powerMode             <= m;
        standby_pin_level_sel <= s;
        settle(2);
    endtask : mode

    task t_reset;
        // each reset source in turn, with a write tried while it is active
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            external_reset_n <= (s != 0);
            porReset         <= (s == 1);
            lvdReset         <= (s == 2);
            internalReset    <= (s == 3);
            wr('{gpioOut: 8'hFF, gpioOe: 8'hFF, periphEn: 4'h0, relocSel: 4'h0});
            settle(3);
            chk(pinOe, 8'h00);
            chk(gpioIn, 8'h00);
            chk({7'h00, cfgWrReady}, 8'h00);
            @(posedge clk);
            {porReset, lvdReset, internalReset} <= 3'h0;
            external_reset_n <= 1'b1;
            settle(2);
            chk(pinOe, 8'h00);
            chk({7'h00, cfgWrReady}, 8'h01);
        end
    endtask : t_reset

    task t_gpio;
        wr('{gpioOut: 8'hA5, gpioOe: 8'h0F, periphEn: 4'h0, relocSel: 4'h0});
        chk(pinOe, 8'h0F);
        chk(pinOut & pinOe, 8'h05);
        settle(1);
        chk(gpioIn, 8'h35);
    endtask : t_gpio

    task t_reloc;
        @(posedge clk);
        periphOut <= 4'h1;
        periphOe  <= 4'h1;
        wr('{gpioOut: 8'h00, gpioOe: 8'h00, periphEn: 4'h1, relocSel: 4'h1});
        chk(pinOut & pinOe, 8'h02);
        // peripheral keeps owning its pin through a keep-state standby
        mode(SPC_MODE_SUB_TIMER, 1'b0);
        @(posedge clk);
        periphOut <= 4'h0;
        settle(2);
        chk(pinOe ^ (pinOut & 8'h02), 8'h02);
        mode(SPC_MODE_RUN, 1'b0);
        @(posedge clk);
        periphOe <= 4'h0;
        settle(3);
        chk({4'h0, periphIn} & 8'h01, 8'h01);
    endtask : t_reloc

    task t_standby;
        @(posedge clk);
        extIntEn <= 8'h22;
        wr('{gpioOut: 8'hA5, gpioOe: 8'hF0, periphEn: 4'h0, relocSel: 4'h0});
        mode(SPC_MODE_STOP, 1'b1);
        chk(pinOe, 8'h20);
        chk(pinOut & pinOe, 8'h20);
        chk(gpioIn, 8'h22);
        mode(SPC_MODE_RUN, 1'b0);
        // held state must survive every mode, with the oscillators per mode
        for (int i = 0; i < 6; i++) begin
            mode(spc_mode_e'(6'h01 << i), 1'b0);
            chk(pinOe, 8'hF0);
            chk({6'h00, hsOscStop, subOscStop}, {6'h00, i >= 2, i == 5});
        end
        wr(SPC_CFG_RESET);
        chk(pinOe, 8'hF0);
    endtask : t_standby

    task give_verdict;
        $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    initial begin
        rst_n = 1'b0;
        external_reset_n = 1'b1;
        {porReset, lvdReset, internalReset} = 3'h0;
        powerMode = SPC_MODE_RUN;
        standby_pin_level_sel = 1'b0;
        cfgWrValid = 1'b0;
        cfgWrData = SPC_CFG_RESET;
        {periphOut, periphOe} = 8'h00;
        extIntEn = 8'h00;
        boardLvl = 8'h3A;
        mismatches = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_gpio;
        t_reloc;
        t_standby;
        give_verdict;
    end

    initial begin
        #200000;
        mismatches++;
        give_verdict;
    end
endmodule : spc_standby_pin_state_control_tb_top
